// ---- design/cmt_min_store.sv ----
// storage of one lowest code per channel, byte-writable
// assumes a single writer; read data come out one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module cmt_min_store
#(
	parameter int DEPTH = 8,
	parameter int AW = 3,
	parameter int W = 16,
	parameter logic [W-1:0] INIT = 16'hffff
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// read port
	input wire logic [AW-1:0] rd_addr,
	output logic [W-1:0] rd_data,
	// write port with two byte enables
	input wire logic wr_en,
	input wire logic [1:0] wr_be,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [W-1:0] wr_data
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= INIT;
			rd_data <= INIT;
		end
		else
		begin
			for (int b = 0; b < 2; b++)
				if (wr_en && wr_be[b])
					mem[wr_addr][b*(W/2) +: (W/2)] <= wr_data[b*(W/2) +: (W/2)];
			rd_data <= mem[rd_addr];
		end
	end
endmodule // cmt_min_store
`default_nettype wire

// ---- design/cmt_pkg.sv ----
// package for the per-channel lowest-code tracker
// assumes one clock domain and an AXI4-Lite register bus with 32-bit data
package cmt_pkg;

	// ----------------------------------------------------------------
	// bus and data widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam int BYTE_W = 8;
	localparam int CODE_W = 2 * BYTE_W;
	localparam int NUM_CH = 8;
	localparam int CH_W = 3;
	localparam int IDX_W = 8;
	localparam int IDX_LSB = 2;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_CH0_MIN_LOW = 8'h80;
	localparam logic [IDX_W-1:0] IDX_CH1_MIN_HIGH = 8'h83;
	localparam logic [IDX_W-1:0] IDX_CH2_MIN_LOW = 8'h84;
	localparam logic [IDX_W-1:0] IDX_CH2_MIN_HIGH = 8'h85;
	localparam logic [IDX_W-1:0] IDX_CH3_MIN_LOW = 8'h86;
	localparam logic [IDX_W-1:0] IDX_CH3_MIN_HIGH = 8'h87;
	localparam logic [IDX_W-1:0] IDX_CH4_MIN_LOW = 8'h88;
	localparam logic [IDX_W-1:0] IDX_CH4_MIN_HIGH = 8'h89;
	localparam logic [IDX_W-1:0] IDX_CH5_MIN_LOW = 8'h8a;
	localparam logic [IDX_W-1:0] IDX_CH5_MIN_HIGH = 8'h8b;
	localparam logic [IDX_W-1:0] IDX_CH6_MIN_LOW = 8'h8c;
	localparam logic [IDX_W-1:0] IDX_CH6_MIN_HIGH = 8'h8d;
	localparam logic [IDX_W-1:0] IDX_CH7_MIN_LOW = 8'h8e;
	localparam logic [IDX_W-1:0] IDX_CH7_MIN_HIGH = 8'h8f;
	localparam logic [IDX_W-1:0] IDX_TRACK_ENABLE = 8'h90;

	// ----------------------------------------------------------------
	// reset values and responses
	// ----------------------------------------------------------------
	localparam logic [BYTE_W-1:0] MIN_BYTE_RESET = 8'hff;
	localparam logic [CODE_W-1:0] MIN_CODE_RESET = 16'hffff;
	localparam logic [NUM_CH-1:0] TRACK_ENABLE_RESET = 8'hff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] BE_LOW = 2'h1;
	localparam logic [1:0] BE_HIGH = 2'h2;
	localparam logic [1:0] BE_BOTH = 2'h3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [CH_W-1:0] ch;
		logic [CODE_W-1:0] code;
	} cmt_conv_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h1,
		S_CMP = 3'h2,
		S_RDATA = 3'h4
	} cmt_state_t;

endpackage

// ---- design/cmt_tracker.sv ----
// per-channel lowest conversion code tracker with AXI4-Lite register access
// assumes conversions arrive synchronous to aclk as channel/code words
//
// Notes on behaviour
// - keep lowest code per channel since read
// - read returns byte, then reloads all ones
// - every minimum byte resets to all ones
// - low byte even address, high byte odd
// - channel addresses advance by two each
`timescale 1ns/1ps
`default_nettype none
module cmt_tracker
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// conversion results
	input wire cmt_pkg::cmt_conv_t conv,
	input wire logic conv_valid,
	output logic conv_ready,
	// write address channel
	input wire logic [cmt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data channel
	input wire logic [cmt_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [cmt_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address channel
	input wire logic [cmt_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data channel
	output logic [cmt_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import cmt_pkg::*;

	// ----------------------------------------------------------------
	// address decode helpers
	// ----------------------------------------------------------------
	function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
		return a[IDX_LSB +: IDX_W];
	endfunction

	function automatic logic addr_in_map(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:IDX_LSB+IDX_W] == '0;
	endfunction

	// channel minimum block spans two indices per channel
	function automatic logic is_min_reg(input logic [ADDR_W-1:0] a);
		return addr_in_map(a) && reg_index(a) >= IDX_CH0_MIN_LOW && reg_index(a) <= IDX_CH7_MIN_HIGH;
	endfunction

	function automatic logic is_enable_reg(input logic [ADDR_W-1:0] a);
		return addr_in_map(a) && reg_index(a) == IDX_TRACK_ENABLE;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	cmt_state_t state;
	cmt_state_t next_state;
	cmt_conv_t conv_q;
	logic [NUM_CH-1:0] track_enable;
	logic ar_held;
	logic [ADDR_W-1:0] ar_addr_q;
	logic aw_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic w_held;
	logic [DATA_W-1:0] w_data_q;
	logic [STRB_W-1:0] w_strb_q;
	logic [CODE_W-1:0] stored_code;

	// ----------------------------------------------------------------
	// read path decode
	// ----------------------------------------------------------------
	wire logic ar_fire = s_axi_arvalid && s_axi_arready;
	wire logic r_fire = s_axi_rvalid && s_axi_rready;
	wire logic next_ar_held = ar_held ? !r_fire : ar_fire;
	wire logic in_idle = state == S_IDLE;
	wire logic in_cmp = state == S_CMP;
	wire logic in_rdata = state == S_RDATA;
	wire logic bus_wait = ar_held && !s_axi_rvalid && !in_rdata;
	wire logic next_rvalid = in_rdata || (s_axi_rvalid && !s_axi_rready);
	wire logic conv_fire = conv_valid && conv_ready && in_idle;
	wire logic [IDX_W-1:0] ar_idx = reg_index(ar_addr_q);
	// even index is the low byte, odd the high byte
	wire logic ar_high = ar_idx[0];
	// channel number from index bits above the byte select
	wire logic [CH_W-1:0] ar_ch = ar_idx[CH_W:1];
	wire logic ar_is_min = is_min_reg(ar_addr_q);
	wire logic ar_is_enable = is_enable_reg(ar_addr_q);
	wire logic [BYTE_W-1:0] held_byte = ar_high ? stored_code[CODE_W-1:BYTE_W] : stored_code[BYTE_W-1:0];

	// ----------------------------------------------------------------
	// sequencing: one store access per cycle, bus read or conversion
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		unique case (state)
			S_IDLE:
			begin
				if (conv_fire)
					next_state = S_CMP;
				else if (bus_wait)
					next_state = S_RDATA;
			end
			S_CMP:
				next_state = S_IDLE;
			S_RDATA:
				next_state = S_IDLE;
		endcase
	end

	wire logic next_in_rdata = next_state == S_RDATA;
	wire logic next_bus_wait = next_ar_held && !next_rvalid && !next_in_rdata;
	// a waiting bus read closes the door to conversions so it cannot starve
	wire logic next_conv_ready = next_state == S_IDLE && !next_bus_wait;

	// ----------------------------------------------------------------
	// store access
	// ----------------------------------------------------------------
	wire logic [CH_W-1:0] store_rd_addr = conv_fire ? conv.ch : ar_ch;
	// full sixteen-bit compare, strictly lower only
	wire logic code_lower = conv_q.code < stored_code;
	// update only from the channel's own conversions
	wire logic cmp_write = in_cmp && code_lower && track_enable[conv_q.ch];
	// read of a minimum byte reloads that byte with ones
	wire logic clear_write = in_rdata && ar_is_min;
	wire logic store_we = cmp_write || clear_write;
	wire logic [1:0] store_be = in_cmp ? BE_BOTH : (ar_high ? BE_HIGH : BE_LOW);
	wire logic [CH_W-1:0] store_wr_addr = in_cmp ? conv_q.ch : ar_ch;
	wire logic [CODE_W-1:0] store_wr_data = in_cmp ? conv_q.code : MIN_CODE_RESET;

	// store comes out of reset holding all ones
	cmt_min_store #(
		.DEPTH(NUM_CH),
		.AW(CH_W),
		.W(CODE_W),
		.INIT(MIN_CODE_RESET)
	) u_store (
		.aclk(aclk),
		.aresetn(aresetn),
		.rd_addr(store_rd_addr),
		.rd_data(stored_code),
		.wr_en(store_we),
		.wr_be(store_be),
		.wr_addr(store_wr_addr),
		.wr_data(store_wr_data)
	);

	// ----------------------------------------------------------------
	// read data selection
	// ----------------------------------------------------------------
	wire logic [DATA_W-1:0] read_word = ar_is_min ? {{(DATA_W-BYTE_W){1'b0}}, held_byte} :
		ar_is_enable ? {{(DATA_W-NUM_CH){1'b0}}, track_enable} : '0;
	wire logic [1:0] read_resp = (ar_is_min || ar_is_enable) ? RESP_OKAY : RESP_SLVERR;

	// ----------------------------------------------------------------
	// write path decode
	// ----------------------------------------------------------------
	wire logic aw_fire = s_axi_awvalid && s_axi_awready;
	wire logic w_fire = s_axi_wvalid && s_axi_wready;
	wire logic write_go = aw_held && w_held && !s_axi_bvalid;
	wire logic next_aw_held = write_go ? 1'b0 : (aw_held || aw_fire);
	wire logic next_w_held = write_go ? 1'b0 : (w_held || w_fire);
	wire logic next_bvalid = write_go || (s_axi_bvalid && !s_axi_bready);
	wire logic aw_is_enable = is_enable_reg(aw_addr_q);
	wire logic enable_write = write_go && aw_is_enable && w_strb_q[0];
	wire logic [1:0] write_resp = aw_is_enable ? RESP_OKAY : RESP_SLVERR;

	// ----------------------------------------------------------------
	// sequencer and conversion capture
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= S_IDLE;
			conv_ready <= 1'b0;
			conv_q <= '0;
		end
		else
		begin
			state <= next_state;
			conv_ready <= next_conv_ready;
			if (conv_fire)
				conv_q <= conv;
		end
	end

	// ----------------------------------------------------------------
	// read channels
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ar_held <= 1'b0;
			ar_addr_q <= '0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			ar_held <= next_ar_held;
			s_axi_arready <= !next_ar_held;
			s_axi_rvalid <= next_rvalid;
			if (ar_fire)
				ar_addr_q <= s_axi_araddr;
			// held value leaves on the bus as the byte is reloaded
			if (in_rdata)
			begin
				s_axi_rdata <= read_word;
				s_axi_rresp <= read_resp;
			end
		end
	end

	// ----------------------------------------------------------------
	// write channels and tracking enable register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			track_enable <= TRACK_ENABLE_RESET;
		end
		else
		begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready <= !next_w_held && !next_bvalid;
			s_axi_bvalid <= next_bvalid;
			if (aw_fire)
				aw_addr_q <= s_axi_awaddr;
			if (w_fire)
			begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (write_go)
				s_axi_bresp <= write_resp;
			if (enable_write)
				track_enable <= w_data_q[NUM_CH-1:0];
		end
	end
endmodule // cmt_tracker
`default_nettype wire

// ---- tb/cmt_tracker_assertions.sv ----
// checker for the lowest-code tracker bus and conversion timing
// assumes it is bound to cmt_tracker and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module cmt_tracker_assertions
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// conversions
	input wire logic conv_valid,
	input wire logic conv_ready,
	// write channels
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read channels
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [cmt_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import cmt_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------
	// handshakes
	// ------------
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence r_take;
		s_axi_rvalid && s_axi_rready;
	endsequence
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// ------------
	// properties
	// ------------
	AST_READ_ANSWER: assert property (ar_take |-> ##[3:4] s_axi_rvalid)
		else $error("read answer late");
	AST_READ_SINGLE: assert property (ar_take |=> !s_axi_arready until r_take)
		else $error("read address taken twice");
	AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	AST_READ_WIDTH: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data wider than a byte");
	AST_READ_REFUSE: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read returns data");
	AST_READ_REARM: assert property (r_take |=> !s_axi_rvalid && s_axi_arready)
		else $error("read path not rearmed");
	AST_WRITE_ANSWER: assert property (wr_take |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	AST_CONV_GAP: assert property (conv_valid && conv_ready |=> !conv_ready ##[1:6] conv_ready)
		else $error("conversion spacing wrong");
endmodule // cmt_tracker_assertions
bind cmt_tracker cmt_tracker_assertions cmt_tracker_assertions_i
(
	.aclk, .aresetn, .conv_valid, .conv_ready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ---- tb/cmt_tracker_test.sv ----
// self-checking bench for the lowest-code tracker
// assumes the package and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module cmt_tracker_test;
	import cmt_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, conv_valid = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [DATA_W-1:0] s_axi_wdata = 32'h0;
	logic [STRB_W-1:0] s_axi_wstrb = 4'hf;
	cmt_conv_t conv = '0;
	logic conv_ready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [DATA_W-1:0] s_axi_rdata;
	int fail_count = 0, checked = 0;
	cmt_tracker cmt_tracker_i
	(
		.aclk, .aresetn, .conv, .conv_valid, .conv_ready,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	initial
	begin
		forever #12.5 aclk = ~aclk;
	end
	// ------------
	// tasks
	// ------------
	task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic rd(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp, input logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		// stall so the answer has to stand
		repeat (3) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, exp);
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, resp});
	endtask
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] data, input logic [1:0] resp);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= data;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge aclk);
			aw = aw || s_axi_awready === 1'b1;
			w = w || s_axi_wready === 1'b1;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		repeat (3) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, resp});
	endtask
	task automatic cv(input logic [CH_W-1:0] ch, input logic [CODE_W-1:0] code);
		@(posedge aclk);
		conv <= '{ch: ch, code: code};
		conv_valid <= 1'b1;
		do @(posedge aclk); while (conv_ready !== 1'b1);
		conv_valid <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic end_sim;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ------------
	// tests
	// ------------
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 'h83; i <= 'h8e; i++)
			rd(IDX_W'(i), 32'hff, RESP_OKAY);
		rd(8'h91, 32'h0, RESP_SLVERR);
		wr(8'h84, 32'h0, RESP_SLVERR);
		rd(8'h84, 32'hff, RESP_OKAY);
		$display("test reset done");
		for (int c = 1; c < 8; c++)
		begin
			cv(CH_W'(c), {8'(c), 8'(c + 16)});
			if (c > 1)
				rd(8'h80 + 8'(2 * c), 32'(c + 16), RESP_OKAY);
			if (c < 7)
				rd(8'h81 + 8'(2 * c), 32'(c), RESP_OKAY);
		end
		rd(8'h84, 32'hff, RESP_OKAY);
		$display("test map done");
		cv(3'h2, 16'h1234);
		cv(3'h2, 16'h5678);
		cv(3'h2, 16'h1233);
		rd(8'h84, 32'h33, RESP_OKAY);
		rd(8'h85, 32'h12, RESP_OKAY);
		cv(3'h5, 16'h2050);
		rd(8'h8a, 32'h50, RESP_OKAY);
		cv(3'h5, 16'h20a0);
		cv(3'h5, 16'h2100);
		rd(8'h8b, 32'h20, RESP_OKAY);
		rd(8'h8a, 32'ha0, RESP_OKAY);
		rd(8'h8b, 32'hff, RESP_OKAY);
		$display("test lowest done");
		wr(IDX_TRACK_ENABLE, 32'hf7, RESP_OKAY);
		rd(IDX_TRACK_ENABLE, 32'hf7, RESP_OKAY);
		cv(3'h3, 16'h0001);
		rd(8'h86, 32'hff, RESP_OKAY);
		wr(IDX_TRACK_ENABLE, 32'hff, RESP_OKAY);
		cv(3'h3, 16'h0001);
		rd(8'h86, 32'h01, RESP_OKAY);
		// a write without the low byte lane changes nothing
		s_axi_wstrb <= 4'he;
		wr(IDX_TRACK_ENABLE, 32'h00, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(IDX_TRACK_ENABLE, 32'hff, RESP_OKAY);
		$display("test enable done");
		end_sim();
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		end_sim();
	end
endmodule // cmt_tracker_test
`default_nettype wire
